//--- rtl/idts_cfg.svh
// Constants of the interrupt-driven transfer service: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the engine module.
`ifndef IDTS_CFG_SVH
`define IDTS_CFG_SVH

// ----------------------------------------------------------------------------
// Register byte offsets on the bus
// ----------------------------------------------------------------------------
`define IDTS_REG_CTRL      8'h00
`define IDTS_REG_STATUS    8'h04
`define IDTS_REG_COUNT     8'h08

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define IDTS_CTRL_ENABLE   0
`define IDTS_CTRL_MAPHIGH  1
`define IDTS_STAT_DONE     1
`define IDTS_STAT_LOST     2
`define IDTS_STAT_VECT     3
`define IDTS_CTRL_RESET    2'h0

// ----------------------------------------------------------------------------
// Address map of descriptors and peripheral registers (upper bits)
// ----------------------------------------------------------------------------
`define IDTS_WIN_LOW       12'h0FE
`define IDTS_WIN_HIGH      12'hFFE
`define IDTS_SFR_LOW       12'h0FF
`define IDTS_SFR_HIGH      12'hFFF

// ----------------------------------------------------------------------------
// Service kinds and descriptor word counts
// ----------------------------------------------------------------------------
`define IDTS_KIND_B        2'h0
`define IDTS_KIND_C        2'h1
`define IDTS_KIND_CNT      2'h2
`define IDTS_WORDS_B       3'h3
`define IDTS_WORDS_C       3'h5
`define IDTS_WORDS_RING    3'h6
`define IDTS_WORDS_CNT     3'h1

// ----------------------------------------------------------------------------
// Timing: priority resolution in clock cycles
// ----------------------------------------------------------------------------
`define IDTS_PRIO_CYCLES   8

`endif

//--- rtl/idts_pkg.sv
// Types of the interrupt-driven transfer service.
// Assumes idts_cfg.svh holds the numeric constants.
package idts_pkg;

  // --------------------------------------------------------------------------
  // Engine states
  // --------------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE, ST_PEND, ST_DREAD, ST_XA, ST_XB, ST_XC, ST_XD, ST_XE,
    ST_UPD, ST_DWRITE, ST_FINISH
  } idts_phase_type;

  // --------------------------------------------------------------------------
  // Mode byte of a request, memory operation and whole module state
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] kind;
    logic       sfr_to_mem;
    logic       wide;
    logic       down;
    logic       step_timing;
    logic       auto_add;
    logic       ring;
  } idts_mode_type;

  typedef struct packed {
    logic        req;
    logic [19:0] addr;
    logic        write;
    logic        wide;
    logic [15:0] wdata;
  } idts_mem_op_type;

  typedef struct packed {
    idts_phase_type  st;
    logic [2:0]      pcnt;
    logic [2:0]      k;
    logic [2:0]      nf;
    logic [7:0]      chan;
    idts_mode_type   mode;
    logic [5:0][15:0] desc;
    logic [15:0]     data;
    logic [15:0]     cmp;
    idts_mem_op_type mem;
    logic            enable;
    logic            map_high;
    logic            done;
    logic            lost;
    logic            vect;
    logic [15:0]     svc_count;
    logic [7:0]      last_chan;
    logic            wr_pend;
    logic [7:0]      wr_addr;
    logic [31:0]     hrdata;
    logic            hreadyout;
    logic            hresp;
    logic            vector_req;
    logic [7:0]      vector_channel;
    logic            svc_done;
  } idts_state_type;

endpackage

//--- rtl/idts_engine.sv
// Interrupt-driven transfer engine with an AHB-Lite register slave.
// Assumes a single-clock memory port that acknowledges each request with a
// one-cycle mem_ack, and an interrupt controller pulsing svc_req.
//
// Design decisions made here: the AHB-Lite register port and the address map.
`timescale 1ns/100ps
`include "idts_cfg.svh"

// What this block does
// - Type B moves one item between buffer and register, direction from mode.
// - One item of 8 or 16 bits per request, repeated over counted requests.
// - Type B buffer wraps in 64 Kbytes for bytes, spans 1 Mbyte for words.
// - Type B register address is its pointer byte under implied upper bits.
// - The transfer counter is 16 bits and holds transfers still to do.
// - Each transfer decrements the counter, ring operation included.
// - Descriptors live in a 256-byte window chosen by the memory map.
// - Channel pointer gives low byte of the counter address in the window.
// - Type C writes a timer register and a data register per request.
// - Timing pointer is held or stepped by item size, in the pattern pointer's direction.
// - Pattern pointer steps one up or down after a transfer, or rewinds by ring length at a ring wrap.
// - Auto addition writes compare value plus fetched item, else the item.
// - Timing pointer fetches timing items, pattern pointer output patterns.
// - Type C takes timer and output register pointers from separate bytes.
// - Ring control repeats a pattern table of modulo length using step count.
// - Counter reaching zero raises a vectored request instead of more service.
// - Counter mode moves no data, only counts down and raises the vector.
// - Mode byte selects stepping, automatic addition and ring control.
// - A new request waits eight cycles for priority before service begins.
module idts_engine (
  input  wire logic                   clock,
  input  wire logic                   reset,
  input  wire logic                   svc_req,
  input  wire logic [7:0]             svc_channel,
  input  wire idts_pkg::idts_mode_type svc_mode,
  output idts_pkg::idts_mem_op_type   mem,
  input  wire logic                   mem_ack,
  input  wire logic [15:0]            mem_rdata,
  output logic                        vector_req,
  output logic [7:0]                  vector_channel,
  output logic                        svc_done,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic [31:0]                 hrdata
);

  // --------------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------------
  // Pointer step of one or two, optionally confined to its 64-Kbyte page
  function automatic logic [19:0] step_ptr(input logic [19:0] p, input logic down,
                                           input logic wide, input logic wrap64k);
    logic [19:0] d;
    logic [19:0] r;
    d = wide ? 20'h00002 : 20'h00001;
    r = down ? p - d : p + d;
    step_ptr = wrap64k ? {p[19:16], r[15:0]} : r;
  endfunction

  // Address of descriptor word k below the counter word
  function automatic logic [19:0] win_addr(input logic map_high, input logic [7:0] chan,
                                           input logic [2:0] k);
    win_addr = {map_high ? `IDTS_WIN_HIGH : `IDTS_WIN_LOW,
                8'(chan - {4'h0, k, 1'b0})};
  endfunction

  // Full address of a peripheral register from its low byte
  function automatic logic [19:0] sfr_addr(input logic map_high, input logic [7:0] ptr);
    sfr_addr = {map_high ? `IDTS_SFR_HIGH : `IDTS_SFR_LOW, ptr};
  endfunction

  // --------------------------------------------------------------------------
  // State and descriptor field views
  // --------------------------------------------------------------------------
  idts_pkg::idts_state_type  s;
  idts_pkg::idts_state_type  next_s;
  idts_pkg::idts_mem_op_type op;
  logic                      has_op;
  logic                      advance;
  logic [15:0]               rd;
  logic [19:0]               b_ptr;
  logic [7:0]                b_peripheral_reg_pointer;
  logic [7:0]                t_peripheral_reg_pointer;
  logic [7:0]                d_peripheral_reg_pointer;
  logic [19:0]               pattern_pointer;
  logic [19:0]               timing_pointer;
  logic [19:0]               mpd_next;
  logic [19:0]               mpt_next;
  logic [7:0]                ring_mod;
  logic [7:0]                ring_step;
  logic [7:0]                ring_next;
  logic                      is_c;

  // Descriptor fields; bits 20 to 23 of each pointer are not used
  assign b_ptr     = {s.desc[2][3:0], s.desc[1]};
  assign b_peripheral_reg_pointer    = s.desc[2][15:8];
  assign t_peripheral_reg_pointer    = s.desc[1][7:0];
  assign d_peripheral_reg_pointer    = s.desc[1][15:8];
  assign pattern_pointer       = {s.desc[3][3:0], s.desc[2]};
  assign timing_pointer       = {s.desc[3][11:8], s.desc[4]};
  assign ring_mod  = s.desc[5][7:0];
  assign ring_step = s.desc[5][15:8];
  assign is_c      = (s.mode.kind == `IDTS_KIND_C);
  assign rd        = s.mem.wide ? mem_rdata : {8'h00, mem_rdata[7:0]};

  // Type C pointer and ring updates
  always_comb begin
    ring_next = ring_step - 8'h01;
    mpd_next  = step_ptr(pattern_pointer, s.mode.down, 1'b0, 1'b0);
    mpt_next  = s.mode.step_timing ? step_ptr(timing_pointer, s.mode.down, s.mode.wide, 1'b0) : timing_pointer;
    if (s.mode.ring && ring_next == 8'h00) begin
      ring_next = ring_mod;
      mpd_next  = s.mode.down ? pattern_pointer + {12'h000, ring_mod} - 20'h00001
                              : pattern_pointer - {12'h000, ring_mod} + 20'h00001;
    end
  end

  // --------------------------------------------------------------------------
  // Memory operation chosen by the current phase
  // --------------------------------------------------------------------------
  always_comb begin
    op     = '0;
    has_op = 1'b1;
    op.req = 1'b1;
    case (s.st)
      idts_pkg::ST_DREAD: begin
        op.addr = win_addr(s.map_high, s.chan, s.k);
        op.wide = 1'b1;
      end
      idts_pkg::ST_DWRITE: begin
        op.addr  = win_addr(s.map_high, s.chan, s.k);
        op.write = 1'b1;
        op.wide  = 1'b1;
        op.wdata = s.desc[s.k];
      end
      idts_pkg::ST_XA: begin
        // Source read: timing item, peripheral register or buffer
        op.wide = s.mode.wide;
        if (is_c) begin
          op.addr = timing_pointer;
        end else if (s.mode.sfr_to_mem) begin
          op.addr = sfr_addr(s.map_high, b_peripheral_reg_pointer);
        end else begin
          op.addr = b_ptr;
        end
      end
      idts_pkg::ST_XB: begin
        op.wide = s.mode.wide;
        if (is_c) begin
          // Compare value read, only with automatic addition
          op.addr = sfr_addr(s.map_high, t_peripheral_reg_pointer);
          has_op  = s.mode.auto_add;
        end else begin
          op.write = 1'b1;
          op.wdata = s.data;
          op.addr  = s.mode.sfr_to_mem ? b_ptr : sfr_addr(s.map_high, b_peripheral_reg_pointer);
        end
      end
      idts_pkg::ST_XC: begin
        // Timer register write, sum or plain item
        op.addr  = sfr_addr(s.map_high, t_peripheral_reg_pointer);
        op.write = 1'b1;
        op.wide  = s.mode.wide;
        op.wdata = s.data + s.cmp;
      end
      idts_pkg::ST_XD: begin
        op.addr = pattern_pointer;
      end
      idts_pkg::ST_XE: begin
        // Pattern write to the output register
        op.addr  = sfr_addr(s.map_high, d_peripheral_reg_pointer);
        op.write = 1'b1;
        op.wdata = {8'h00, s.data[7:0]};
      end
      default: begin
        has_op = 1'b0;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Next state: bus slave, sequencer and status flags
  // --------------------------------------------------------------------------
  always_comb begin
    next_s            = s;
    next_s.vector_req = 1'b0;
    next_s.svc_done   = 1'b0;
    next_s.wr_pend    = 1'b0;
    next_s.hreadyout  = 1'b1;
    next_s.hresp      = 1'b0;
    advance           = 1'b0;

    // Data phase of a bus write; status bits clear on writing one
    if (s.wr_pend) begin
      case (s.wr_addr)
        `IDTS_REG_CTRL: begin
          next_s.enable   = hwdata[`IDTS_CTRL_ENABLE];
          next_s.map_high = hwdata[`IDTS_CTRL_MAPHIGH];
        end
        `IDTS_REG_STATUS: begin
          if (hwdata[`IDTS_STAT_DONE]) next_s.done = 1'b0;
          if (hwdata[`IDTS_STAT_LOST]) next_s.lost = 1'b0;
          if (hwdata[`IDTS_STAT_VECT]) next_s.vect = 1'b0;
        end
        default: begin
        end
      endcase
    end

    // Issue a memory operation and wait for its acknowledge
    if (has_op) begin
      if (!s.mem.req) begin
        next_s.mem = op;
      end else if (mem_ack) begin
        next_s.mem.req = 1'b0;
        advance        = 1'b1;
      end
    end

    // Service sequencer
    case (s.st)
      idts_pkg::ST_IDLE: begin
        if (svc_req && s.enable) begin
          next_s.st   = idts_pkg::ST_PEND;
          next_s.pcnt = 3'h0;
          next_s.chan = svc_channel;
          next_s.mode = svc_mode;
        end
      end
      idts_pkg::ST_PEND: begin
        // Priority resolution delay
        next_s.pcnt = s.pcnt + 3'h1;
        if (s.pcnt == 3'(`IDTS_PRIO_CYCLES - 1)) begin
          next_s.st = idts_pkg::ST_DREAD;
          next_s.k  = 3'h0;
          case (s.mode.kind)
            `IDTS_KIND_C:   next_s.nf = s.mode.ring ? `IDTS_WORDS_RING : `IDTS_WORDS_C;
            `IDTS_KIND_CNT: next_s.nf = `IDTS_WORDS_CNT;
            default:        next_s.nf = `IDTS_WORDS_B;
          endcase
        end
      end
      idts_pkg::ST_DREAD: begin
        if (advance) begin
          next_s.desc[s.k] = mem_rdata;
          if (s.k == s.nf - 3'h1) begin
            // Counter mode skips every data transfer
            next_s.st = (s.mode.kind == `IDTS_KIND_CNT) ? idts_pkg::ST_UPD : idts_pkg::ST_XA;
          end else begin
            next_s.k = s.k + 3'h1;
          end
        end
      end
      idts_pkg::ST_XA: begin
        if (advance) begin
          next_s.data = rd;
          next_s.st   = idts_pkg::ST_XB;
        end
      end
      idts_pkg::ST_XB: begin
        if (is_c && !s.mode.auto_add) begin
          next_s.cmp = 16'h0000;
          next_s.st  = idts_pkg::ST_XC;
        end else if (advance) begin
          next_s.cmp = rd;
          next_s.st  = is_c ? idts_pkg::ST_XC : idts_pkg::ST_UPD;
        end
      end
      idts_pkg::ST_XC: begin
        if (advance) next_s.st = idts_pkg::ST_XD;
      end
      idts_pkg::ST_XD: begin
        if (advance) begin
          next_s.data = rd;
          next_s.st   = idts_pkg::ST_XE;
        end
      end
      idts_pkg::ST_XE: begin
        if (advance) next_s.st = idts_pkg::ST_UPD;
      end
      idts_pkg::ST_UPD: begin
        // One transfer done: count down and step pointers
        next_s.desc[0] = s.desc[0] - 16'h0001;
        if (s.mode.kind == `IDTS_KIND_B) begin
          // Byte items stay in their 64-Kbyte page
          {next_s.desc[2][3:0], next_s.desc[1]} =
            step_ptr(b_ptr, 1'b0, s.mode.wide, !s.mode.wide);
        end else if (is_c) begin
          next_s.desc[2]       = mpd_next[15:0];
          next_s.desc[3][3:0]  = mpd_next[19:16];
          next_s.desc[3][11:8] = mpt_next[19:16];
          next_s.desc[4]       = mpt_next[15:0];
          if (s.mode.ring) next_s.desc[5][15:8] = ring_next;
        end
        next_s.k  = s.nf - 3'h1;
        next_s.st = idts_pkg::ST_DWRITE;
      end
      idts_pkg::ST_DWRITE: begin
        if (advance) begin
          if (s.k == 3'h0) begin
            next_s.st = idts_pkg::ST_FINISH;
          end else begin
            next_s.k = s.k - 3'h1;
          end
        end
      end
      idts_pkg::ST_FINISH: begin
        next_s.svc_done  = 1'b1;
        next_s.done      = 1'b1;
        next_s.svc_count = s.svc_count + 16'h0001;
        next_s.last_chan = s.chan;
        if (s.desc[0] == 16'h0000) begin
          // Count used up: hand over to a vectored interrupt
          next_s.vector_req     = 1'b1;
          next_s.vector_channel = s.chan;
          next_s.vect           = 1'b1;
        end
        next_s.st = idts_pkg::ST_IDLE;
      end
      default: begin
        next_s.st = idts_pkg::ST_IDLE;
      end
    endcase

    // A request that cannot be taken is recorded; set wins over clear
    if (svc_req && !(s.st == idts_pkg::ST_IDLE && s.enable)) next_s.lost = 1'b1;

    // Address phase: reads answer at once, writes complete next cycle
    if (hsel && htrans[1] && hready) begin
      next_s.wr_pend = hwrite;
      next_s.wr_addr = haddr[7:0];
      if (!hwrite) begin
        case (haddr[7:0])
          `IDTS_REG_CTRL:   next_s.hrdata = {30'h0, s.map_high, s.enable};
          `IDTS_REG_STATUS: next_s.hrdata = {16'h0, s.last_chan, 4'h0, s.vect, s.lost,
                                             s.done, s.st != idts_pkg::ST_IDLE};
          `IDTS_REG_COUNT:  next_s.hrdata = {16'h0, s.svc_count};
          default:          next_s.hrdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // State register and outputs
  // --------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      s           <= '0;
      s.hreadyout <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign mem            = s.mem;
  assign vector_req     = s.vector_req;
  assign vector_channel = s.vector_channel;
  assign svc_done       = s.svc_done;
  assign hreadyout      = s.hreadyout;
  assign hresp          = s.hresp;
  assign hrdata         = s.hrdata;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  pend_eight_a: assert property (
    $rose(s.st == idts_pkg::ST_PEND) |-> (s.st == idts_pkg::ST_PEND)[*8]
                                         ##1 (s.st == idts_pkg::ST_DREAD))
    else $error("priority wait is not eight cycles");

  count_down_a: assert property (
    $rose(s.st == idts_pkg::ST_DWRITE) |-> s.desc[0] == $past(s.desc[0]) - 16'h0001)
    else $error("transfer counter not decremented by one");

  vector_zero_a: assert property (
    s.vector_req |-> (s.desc[0] == 16'h0000) && ($past(s.st) == idts_pkg::ST_FINISH))
    else $error("vector raised with counter not zero");

  vector_taken_a: assert property (
    (s.st == idts_pkg::ST_FINISH && s.desc[0] == 16'h0000) |=> s.vector_req)
    else $error("counter at zero gave no vector");

  window_addr_a: assert property (
    (s.mem.req && (s.st == idts_pkg::ST_DREAD || s.st == idts_pkg::ST_DWRITE))
      |-> s.mem.addr[19:8] == (s.map_high ? `IDTS_WIN_HIGH : `IDTS_WIN_LOW))
    else $error("descriptor access outside window");

  chan_locate_a: assert property (
    (s.mem.req && s.st == idts_pkg::ST_DREAD && s.k == 3'h0) |-> s.mem.addr[7:0] == s.chan)
    else $error("counter word not at channel pointer");

  count_only_a: assert property (
    (s.mode.kind == `IDTS_KIND_CNT && s.mem.req)
      |-> (s.st == idts_pkg::ST_DREAD || s.st == idts_pkg::ST_DWRITE))
    else $error("counter mode moved data");

  byte_wrap_a: assert property (
    ($rose(s.st == idts_pkg::ST_DWRITE) && s.mode.kind == `IDTS_KIND_B && !s.mode.wide)
      |-> b_ptr[19:16] == $past(b_ptr[19:16]) && b_ptr[15:0] == $past(b_ptr[15:0]) + 16'h1)
    else $error("byte buffer pointer left its page");

  word_step_a: assert property (
    ($rose(s.st == idts_pkg::ST_DWRITE) && s.mode.kind == `IDTS_KIND_B && s.mode.wide)
      |-> b_ptr == $past(b_ptr) + 20'h00002)
    else $error("word buffer pointer not stepped by two");

  pattern_step_a: assert property (
    ($rose(s.st == idts_pkg::ST_DWRITE) && is_c && !s.mode.ring)
      |-> pattern_pointer == (s.mode.down ? $past(pattern_pointer) - 20'h00001 : $past(pattern_pointer) + 20'h00001))
    else $error("pattern pointer not stepped");

  timing_hold_a: assert property (
    ($rose(s.st == idts_pkg::ST_DWRITE) && is_c && !s.mode.step_timing) |-> timing_pointer == $past(timing_pointer))
    else $error("held timing pointer changed");

endmodule

//--- testbench/idts_mem_model.sv
// Byte memory and peripheral registers behind the engine's memory port.
// Assumes little-endian words; ack one cycle after req, or four when slow.
`timescale 1ns/100ps
module idts_mem_model (
  input  wire logic                      clock,
  input  wire logic                      slow,
  input  wire idts_pkg::idts_mem_op_type mem,
  output logic                           mem_ack = 1'b0,
  output logic [15:0]                    mem_rdata = 16'h5A5A
);
  logic [7:0] bytes [logic [19:0]];
  int         wait_cnt = 0;

  // Answer each request once; read data is only good in the ack cycle
  always @(posedge clock) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem.req === 1'b1 && !mem_ack) begin
      if (wait_cnt < (slow ? 3 : 0)) begin
        wait_cnt <= wait_cnt + 1;
      end else begin
        wait_cnt <= 0;
        mem_ack <= 1'b1;
        if (mem.write) begin
          bytes[mem.addr] = mem.wdata[7:0];
          if (mem.wide) bytes[mem.addr + 20'h1] = mem.wdata[15:8];
        end else begin
          mem_rdata <= {mem.wide ? bytes[mem.addr + 20'h1] : 8'h00, bytes[mem.addr]};
        end
      end
    end
  end
endmodule

//--- testbench/tb.sv
// Bench of the transfer engine: bus tasks, service requests, memory checks.
// Assumes idts_mem_model stands on the memory port.
`timescale 1ns/100ps
module tb;
  logic                      clock = 0, reset = 1, svc_req = 0, hsel = 0, hwrite = 0, slow = 0;
  logic                      mem_ack, vector_req, svc_done, hreadyout, hresp, v;
  logic [7:0]                svc_channel = 8'h00, vector_channel;
  idts_pkg::idts_mode_type   svc_mode = '0;
  idts_pkg::idts_mem_op_type mem;
  logic [15:0]               mem_rdata;
  logic [31:0]               haddr = '0, hwdata = '0, hrdata, r;
  logic [1:0]                htrans = 2'h0;
  int                        bad_count = 0, num_checks = 0, cyc = 0;

  idts_engine dut (.clock(clock), .reset(reset), .svc_req(svc_req), .svc_channel(svc_channel),
    .svc_mode(svc_mode), .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .vector_req(vector_req), .vector_channel(vector_channel), .svc_done(svc_done),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
  idts_mem_model mdl (.clock(clock), .slow(slow), .mem(mem), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));

  // Clock and hang guard
  initial forever #25 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (bad_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  // One single AHB-Lite transfer; read data taken at the data-phase edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    q = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic w16(input logic [19:0] a, input logic [15:0] d);
    mdl.bytes[a] = d[7:0];
    mdl.bytes[a + 20'h1] = d[15:8];
  endtask

  function automatic logic [31:0] r16(input logic [19:0] a);
    return {16'h0, mdl.bytes[a + 20'h1], mdl.bytes[a]};
  endfunction

  // One request; waits for the end of service and notes any vector
  task automatic svc(input logic [7:0] ch, input logic [7:0] md, input logic ev);
    int n;
    int f;
    n = 0;
    f = 0;
    v = 1'b0;
    svc_req <= 1'b1;
    svc_channel <= ch;
    svc_mode <= idts_pkg::idts_mode_type'(md);
    @(posedge clock);
    svc_req <= 1'b0;
    do begin
      @(posedge clock);
      n++;
      if (mem.req === 1'b1 && f == 0) f = n;
      if (vector_req === 1'b1) v = 1'b1;
    end while (svc_done !== 1'b1 && n < 400);
    chk("service_end", 32'h1, 32'(f == 10 && svc_done === 1'b1));
    chk("vector_req", {31'h0, ev}, {31'h0, v});
    if (ev) chk("vector_channel", {24'h0, ch}, {24'h0, vector_channel});
  endtask

  initial begin
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    chk("hreadyout", 32'h1, {31'h0, hreadyout});
    // Request while disabled is dropped and flagged
    svc_req <= 1'b1;
    @(posedge clock);
    svc_req <= 1'b0;
    bus(1'b0, 8'h04, 32'h0, r);
    chk("status_lost", 32'h4, r & 32'h4);
    bus(1'b1, 8'h04, 32'h4, r);
    bus(1'b1, 8'h00, 32'h1, r);
    // Type B bytes to a register, pointer wraps inside its 64 KB page
    w16(20'hFE20, 16'h0002);
    w16(20'hFE1E, 16'hFFFF);
    w16(20'hFE1C, 16'h4002);
    mdl.bytes[20'h2FFFF] = 8'h3C;
    mdl.bytes[20'h20000] = 8'hC3;
    svc(8'h20, 8'h00, 1'b0);
    chk("sfr_first", 32'h3C, {24'h0, mdl.bytes[20'hFF40]});
    chk("count_b", 32'h1, r16(20'hFE20));
    chk("ptr_b", 32'h0, r16(20'hFE1E));
    svc(8'h20, 8'h00, 1'b1);
    chk("sfr_second", 32'hC3, {24'h0, mdl.bytes[20'hFF40]});
    chk("count_b_end", 32'h0, r16(20'hFE20));
    // Type B word from a register to memory, slow memory
    slow <= 1'b1;
    w16(20'hFE40, 16'h0001);
    w16(20'hFE3E, 16'h0000);
    w16(20'hFE3C, 16'h5008);
    w16(20'hFF50, 16'hBEEF);
    svc(8'h40, 8'h30, 1'b1);
    chk("buf_word", 32'hBEEF, r16(20'h80000));
    chk("ptr_word", 32'h0002, r16(20'hFE3E));
    slow <= 1'b0;
    // Type C, word timer, down stepping, automatic addition, ring stepping
    w16(20'hFE80, 16'h0005);
    w16(20'hFE7E, 16'h1810);
    w16(20'hFE7C, 16'h3001);
    w16(20'hFE7A, 16'h0101);
    w16(20'hFE78, 16'h4000);
    w16(20'hFE76, 16'h0202);
    w16(20'h14000, 16'h0234);
    w16(20'hFF10, 16'h1000);
    mdl.bytes[20'h13001] = 8'h5A;
    svc(8'h80, 8'h5F, 1'b0);
    chk("compare_sum", 32'h1234, r16(20'hFF10));
    chk("out_pattern", 32'h5A, {24'h0, mdl.bytes[20'hFF18]});
    chk("count_c", 32'h4, r16(20'hFE80));
    chk("timing_ptr", 32'h3FFE, r16(20'hFE78));
    chk("ring_step", 32'h0102, r16(20'hFE76));
    chk("pattern_ptr", 32'h3000, r16(20'hFE7C));
    // Second ring step wraps: step reloads, pattern pointer rewinds
    w16(20'h13FFE, 16'h0100);
    mdl.bytes[20'h13000] = 8'hA5;
    svc(8'h80, 8'h5F, 1'b0);
    chk("compare_sum2", 32'h1334, r16(20'hFF10));
    chk("out_pattern2", 32'hA5, {24'h0, mdl.bytes[20'hFF18]});
    chk("count_c2", 32'h3, r16(20'hFE80));
    chk("ring_reload", 32'h0202, r16(20'hFE76));
    chk("ring_rewind", 32'h3001, r16(20'hFE7C));
    // Type C, byte timer, up stepping, timing held, plain compare write
    w16(20'hFEA0, 16'h0001);
    w16(20'hFE9E, 16'h1A12);
    w16(20'hFE9C, 16'h2000);
    w16(20'hFE9A, 16'h0202);
    w16(20'hFE98, 16'h5000);
    mdl.bytes[20'h25000] = 8'h77;
    mdl.bytes[20'h22000] = 8'h99;
    mdl.bytes[20'hFF12] = 8'h11;
    svc(8'hA0, 8'h40, 1'b1);
    chk("compare_plain", 32'h77, {24'h0, mdl.bytes[20'hFF12]});
    chk("out_plain", 32'h99, {24'h0, mdl.bytes[20'hFF1A]});
    chk("pattern_up", 32'h2001, r16(20'hFE9C));
    chk("timing_held", 32'h5000, r16(20'hFE98));
    // Counter mode in the upper descriptor window
    bus(1'b1, 8'h00, 32'h3, r);
    w16(20'hFFE10, 16'h0001);
    svc(8'h10, 8'h80, 1'b1);
    chk("count_cnt", 32'h0, r16(20'hFFE10));
    bus(1'b0, 8'h08, 32'h0, r);
    chk("services", 32'h7, r);
    bus(1'b0, 8'h0C, 32'h0, r);
    chk("unmapped", 32'h0, r);
    wrap_up();
  end
endmodule
